// [hw/tsc_counter.sv]
`timescale 1ns/1ps
`default_nettype none

module tsc_counter (
	// clock and reset
	input  wire logic                    CLK,
	input  wire logic                    RST,
	// register port
	input  wire tsc_pkg::tsc_bus_type    BUS,
	output var  logic [7:0]              RDATA,
	// asynchronous event sources
	input  wire tsc_pkg::tsc_src_type    SRC,
	// analog switch controls and interrupt
	output var  tsc_pkg::tsc_analog_type ANALOG,
	output var  logic                    IRQ
);
	import tsc_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	// ==========================================================
	// registers
	logic [7:0] mode_q, inclk_q, sw_q, shref_q, tmr_q, slew_q;
	logic [3:0] mask_q, flag_q, flag_d;
	logic [7:0] cnt_lo_q, cnt_hi_q;
	logic [7:0] rdata_q;
	logic [2:0] div_q;
	logic       sclk_q, in_prev_q;
	logic [7:0] src_s1_q, src_s2_q;
	tsc_state_type state_q, state_d;
	tsc_analog_type analog_q, analog_d;
	logic       irq_q;

	wire wr_mode  = BUS.wr && hit(BUS.addr, ADDR_MODE_CTRL);
	wire wr_inclk = BUS.wr && hit(BUS.addr, ADDR_INPUT_CLK);
	wire wr_sw    = BUS.wr && hit(BUS.addr, ADDR_SWITCH_CTRL);
	wire wr_shref = BUS.wr && hit(BUS.addr, ADDR_SHIELD_REF);
	wire wr_stat  = BUS.wr && hit(BUS.addr, ADDR_STATUS_MASK);
	wire wr_tmr   = BUS.wr && hit(BUS.addr, ADDR_TIMER_VALUE);
	wire wr_slew  = BUS.wr && hit(BUS.addr, ADDR_SLEW_CTRL);

	wire enable   = mode_q[POS_ENABLE];
	wire tsc_mode_type mode = tsc_mode_type'(mode_q[POS_MODE_LO +: 2]);
	wire chain    = inclk_q[POS_CHAIN];
	wire [1:0] div_sel = inclk_q[POS_DIV_LO +: 2];

	// register writes; reserved bits stay as written
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			mode_q  <= REG_RESET;
			inclk_q <= REG_RESET;
			sw_q    <= REG_RESET;
			shref_q <= REG_RESET;
			tmr_q   <= REG_RESET;
			slew_q  <= REG_RESET;
			mask_q  <= 4'h0;
		end else begin
			if (wr_mode)
				mode_q <= BUS.wdata;
			if (wr_inclk)
				inclk_q <= BUS.wdata;
			if (wr_sw)
				sw_q <= BUS.wdata;
			if (wr_shref)
				shref_q <= BUS.wdata;
			if (wr_tmr)
				tmr_q <= BUS.wdata;
			if (wr_slew)
				slew_q <= BUS.wdata;
			if (wr_stat)
				mask_q <= BUS.wdata[3:0];
		end
	end

	// ==========================================================
	// sense clock divider
	// divide select
	wire [2:0] div_top = DIV_MAX >> (3'h3 - {1'b0, div_sel});
	wire       sense_tick = (div_q >= div_top);
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div_q  <= 3'h0;
			sclk_q <= 1'b0;
		end else if (sense_tick) begin
			div_q  <= 3'h0;
			sclk_q <= ~sclk_q;
		end else begin
			div_q  <= div_q + 3'h1;
		end
	end

	// ==========================================================
	// input selection after two-stage synchroniser
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			src_s1_q <= 8'h00;
			src_s2_q <= 8'h00;
		end else begin
			src_s1_q <= SRC.sources;
			src_s2_q <= src_s1_q;
		end
	end
	// source mux, code 7 is zero
	wire [2:0] sel = inclk_q[2:0];
	wire raw_in = (sel == 3'h7) ? 1'b0 : src_s2_q[sel];
	wire sel_in = raw_in ^ inclk_q[POS_INVERT];
	wire rise   = sel_in & ~in_prev_q;
	wire fall   = ~sel_in & in_prev_q;

	// ==========================================================
	// counters and mode sequencing
	wire counting = (state_q == TSC_ST_RUN) && enable;
	wire lo_cy    = counting && (cnt_lo_q == 8'hff);
	// high counts on low carry when chained, else on its own
	wire hi_step  = counting && (chain ? lo_cy : 1'b1);
	wire hi_cy    = hi_step && (cnt_hi_q == 8'hff);
	wire stop_evt = (mode == TSC_MODE_EVENT) && |(flag_d & mask_q);
	wire meas_end = counting && (((mode == TSC_MODE_PULSE) && fall) ||
	                ((mode == TSC_MODE_PERIOD) && rise));

	always_comb begin
		state_d = state_q;
		case (state_q)
			TSC_ST_IDLE: begin
				if (enable)
					state_d = (mode == TSC_MODE_EVENT || mode == TSC_MODE_CONT) ? TSC_ST_RUN : TSC_ST_WAIT;
			end
			TSC_ST_WAIT: begin
				if (rise)
					state_d = TSC_ST_RUN;
			end
			TSC_ST_RUN: begin
				if (meas_end || (stop_evt && counting))
					state_d = TSC_ST_IDLE;
			end
			default: state_d = TSC_ST_IDLE;
		endcase
		if (!enable)
			state_d = TSC_ST_IDLE;
	end

	// stopped counters stay idle until the block is re-enabled
	logic done_q;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q   <= TSC_ST_IDLE;
			in_prev_q <= 1'b0;
			done_q    <= 1'b0;
			cnt_lo_q  <= 8'h00;
			cnt_hi_q  <= 8'h00;
		end else begin
			in_prev_q <= sel_in;
			done_q    <= enable && (done_q || (state_q == TSC_ST_RUN && state_d == TSC_ST_IDLE));
			state_q   <= done_q ? TSC_ST_IDLE : state_d;
			if (!enable) begin
				cnt_lo_q <= 8'h00;
				cnt_hi_q <= 8'h00;
			end else if (counting && !done_q) begin
				cnt_lo_q <= cnt_lo_q + 8'h01;
				if (hi_step)
					cnt_hi_q <= cnt_hi_q + 8'h01;
			end
		end
	end

	// ==========================================================
	// status flags
	// input edge, carries, measurement done
	wire [3:0] set_ev = {rise & enable, lo_cy, hi_cy, meas_end};
	wire [3:0] clr    = wr_stat ? ~BUS.wdata[7:4] : 4'h0;
	assign flag_d = (flag_q & ~clr) | set_ev;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			flag_q <= 4'h0;
			irq_q  <= 1'b0;
		end else begin
			flag_q <= flag_d;
			irq_q  <= |(flag_d & mask_q);
		end
	end

	// ==========================================================
	// analog switch controls
	wire osc_en = sw_q[POS_PIN_SWITCH] | sw_q[POS_POS_INTEG] | sw_q[POS_NEG_INTEG];
	always_comb begin
		analog_d = '0;
		analog_d.sense_clock       = sclk_q;
		analog_d.pin_switch        = sw_q[POS_PIN_SWITCH] & sclk_q;
		analog_d.neg_integ_gnd     = sw_q[POS_NEG_INTEG] & sclk_q;
		analog_d.pos_integ_phase   = sw_q[POS_POS_INTEG] & sclk_q;
		analog_d.dac_bus_connect   = sw_q[POS_DAC_CONNECT] | sw_q[POS_PIN_SWITCH];
		analog_d.ref_bus_connect   = shref_q[POS_REF_ENABLE] &
		                             (osc_en ? sw_q[POS_POS_INTEG] & ~sclk_q : shref_q[POS_REF_MANUAL]);
		analog_d.ref_enable        = shref_q[POS_REF_ENABLE];
		analog_d.ref_voltage_sel   = shref_q[POS_REF_SEL];
		analog_d.current_scale_sel = sw_q[POS_SCALE];
		analog_d.dual_dac_select   = tmr_q[POS_DUAL_DAC];
		analog_d.fast_slew_enable  = slew_q[POS_FAST_SLEW];
		analog_d.shield_enable     = {shref_q[POS_SHIELD_HI], shref_q[3:0]};
		analog_d.timer_count       = tmr_q[6:0];
	end

	// ==========================================================
	// read mux; unmapped addresses read zero
	wire [7:0] rd_mux =
		hit(BUS.addr, ADDR_MODE_CTRL)   ? mode_q :
		hit(BUS.addr, ADDR_INPUT_CLK)   ? inclk_q :
		hit(BUS.addr, ADDR_SWITCH_CTRL) ? sw_q :
		hit(BUS.addr, ADDR_SHIELD_REF)  ? shref_q :
		hit(BUS.addr, ADDR_COUNT_LOW)   ? cnt_lo_q :
		hit(BUS.addr, ADDR_COUNT_HIGH)  ? cnt_hi_q :
		hit(BUS.addr, ADDR_STATUS_MASK) ? {flag_q, mask_q} :
		hit(BUS.addr, ADDR_TIMER_VALUE) ? tmr_q :
		hit(BUS.addr, ADDR_SLEW_CTRL)   ? slew_q : 8'h00;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_q  <= 8'h00;
			analog_q <= '0;
		end else begin
			rdata_q  <= BUS.rd ? rd_mux : 8'h00;
			analog_q <= analog_d;
		end
	end

	assign RDATA  = rdata_q;
	assign ANALOG = analog_q;
	assign IRQ    = irq_q;

endmodule

`default_nettype wire

// [hw/tsc_pkg.sv]
`default_nettype none

package tsc_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_MODE_CTRL   = 8'ha0;
	localparam logic [7:0] ADDR_INPUT_CLK   = 8'ha1;
	localparam logic [7:0] ADDR_SWITCH_CTRL = 8'ha2;
	localparam logic [7:0] ADDR_SHIELD_REF  = 8'ha3;
	localparam logic [7:0] ADDR_COUNT_LOW   = 8'ha4;
	localparam logic [7:0] ADDR_COUNT_HIGH  = 8'ha5;
	localparam logic [7:0] ADDR_STATUS_MASK = 8'ha6;
	localparam logic [7:0] ADDR_TIMER_VALUE = 8'ha7;
	localparam logic [7:0] ADDR_SLEW_CTRL   = 8'ha8;
	localparam logic [7:0] REG_RESET        = 8'h00;

	// ==========================================================
	// field positions
	localparam int POS_ENABLE      = 0;
	localparam int POS_MODE_LO     = 1;
	localparam int POS_CHAIN       = 7;
	localparam int POS_DIV_LO      = 5;
	localparam int POS_INVERT      = 3;
	localparam int POS_SCALE       = 6;
	localparam int POS_DAC_CONNECT = 4;
	localparam int POS_NEG_INTEG   = 3;
	localparam int POS_PIN_SWITCH  = 2;
	localparam int POS_POS_INTEG   = 1;
	localparam int POS_SHIELD_HI   = 7;
	localparam int POS_REF_SEL     = 6;
	localparam int POS_REF_MANUAL  = 5;
	localparam int POS_REF_ENABLE  = 4;
	localparam int POS_FLAG_LO     = 4;
	localparam int POS_DUAL_DAC    = 7;
	localparam int POS_FAST_SLEW   = 0;

	localparam logic [3:0] FLAG_INPUT   = 4'h8;
	localparam logic [3:0] FLAG_LOW_CY  = 4'h4;
	localparam logic [3:0] FLAG_HIGH_CY = 4'h2;
	localparam logic [3:0] FLAG_DONE    = 4'h1;
	localparam logic [2:0] DIV_MAX      = 3'h7;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		TSC_MODE_EVENT  = 2'h0,
		TSC_MODE_PULSE  = 2'h1,
		TSC_MODE_PERIOD = 2'h2,
		TSC_MODE_CONT   = 2'h3
	} tsc_mode_type;

	typedef enum logic [2:0] {
		TSC_ST_IDLE = 3'b001,
		TSC_ST_WAIT = 3'b010,
		TSC_ST_RUN  = 3'b100
	} tsc_state_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tsc_bus_type;

	typedef struct packed {
		logic [7:0] sources;
	} tsc_src_type;

	typedef struct packed {
		logic       sense_clock;
		logic       pin_switch;
		logic       neg_integ_gnd;
		logic       pos_integ_phase;
		logic       dac_bus_connect;
		logic       ref_bus_connect;
		logic       ref_enable;
		logic       ref_voltage_sel;
		logic       current_scale_sel;
		logic       dual_dac_select;
		logic       fast_slew_enable;
		logic [4:0] shield_enable;
		logic [6:0] timer_count;
	} tsc_analog_type;

endpackage

`default_nettype wire

// [sim/touch_sense_counter_tb.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========
// register level bench for the touch sense counter
module touch_sense_counter_tb;
	import tsc_pkg::*;

	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	tsc_bus_type           bus = '0;
	tsc_src_type           src = '0;
	logic [7:0]            rdata;
	tsc_analog_type        an;
	logic                  irq;
	int                    fail_count = 0;
	int                    checked = 0;
	int                    i;
	int                    n;
	logic [7:0]            ra [5] = '{8'ha1, 8'ha2, 8'ha3, 8'ha7, 8'ha8};
	logic [7:0]            rw [5] = '{8'hef, 8'h40, 8'h8f, 8'hff, 8'h01};
	logic [7:0]            rm [5] = '{8'hef, 8'h5e, 8'hff, 8'hff, 8'h01};

	tsc_counter i_tsc_counter (
		.CLK    (clk),
		.RST    (rst),
		.BUS    (bus),
		.RDATA  (rdata),
		.SRC    (src),
		.ANALOG (an),
		.IRQ    (irq)
	);

	// clock; reset is released by the tests
	initial begin
		forever #5 clk = ~clk;
	end

	// ==========
	// bus and compare tasks
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	// one idle cycle after each strobe keeps every signal single-driven per step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		@(negedge clk);
		chk(nm, e, rdata & m);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	// transitions of one analog bit over k cycles
	task automatic edges(input int b, input int k, output int t);
		logic p;
		t = 0;
		p = an[b];
		repeat (k) begin
			@(negedge clk);
			if (an[b] !== p) t++;
			p = an[b];
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard, the tests need some 1800 cycles
	initial begin
		#100000;
		fail_count++;
		tally_and_finish;
	end

	// ==========
	// tests
	initial begin
		cyc(2);
		rst <= 1'b0;
		for (i = 0; i < 9; i++) rd(ADDR_MODE_CTRL + 8'(i), 8'hff, REG_RESET, "reset value");
		rd(8'h10, 8'hff, 8'h00, "unmapped read");
		for (i = 0; i < 5; i++) wr(ra[i], rw[i]);
		wr(ADDR_COUNT_LOW, 8'h55);
		for (i = 0; i < 5; i++) rd(ra[i], rm[i], rw[i] & rm[i], "readback");
		rd(ADDR_COUNT_LOW, 8'hff, 8'h00, "read only count");
		chk("shield", 8'h1f, {3'h0, an.shield_enable});
		chk("timer", 8'hff, {an.dual_dac_select, an.timer_count});
		chk("scale slew", 8'h03, {6'h0, an.current_scale_sel, an.fast_slew_enable});
		$display("test registers done");
		// sense clock toggles every 1, 2, 4, 8 cycles
		for (i = 0; i < 4; i++) begin
			wr(ADDR_INPUT_CLK, {1'b0, i[1:0], 5'h0});
			cyc(3);
			edges(22, 64, n);
			chk("sense clock edges", 8'(64 >> i), 8'(n));
		end
		for (i = 1; i < 4; i++) begin
			wr(ADDR_SWITCH_CTRL, 8'(1 << i));
			cyc(3);
			edges((i == 1) ? 19 : 23 - i, 64, n);
			chk("switch edges", 8'h08, 8'(n));
			chk("dac connect", {7'h0, i == 2}, {7'h0, an.dac_bus_connect});
		end
		wr(ADDR_SWITCH_CTRL, 8'h00);
		cyc(3);
		edges(21, 64, n);
		chk("pins idle", 8'h00, 8'(n));
		// manual reference connect holds only while nothing switches
		wr(ADDR_SHIELD_REF, 8'h70);
		cyc(1);
		@(negedge clk);
		chk("ref manual", 8'h07, {5'h0, an.ref_bus_connect, an.ref_enable, an.ref_voltage_sel});
		wr(ADDR_SWITCH_CTRL, 8'h04);
		cyc(1);
		@(negedge clk);
		chk("ref overridden", 8'h03, {5'h0, an.ref_bus_connect, an.ref_enable, an.ref_voltage_sel});
		wr(ADDR_SWITCH_CTRL, 8'h00);
		$display("test switching done");
		// every source code, plain and inverted
		for (i = 0; i < 16; i++) begin
			wr(ADDR_MODE_CTRL, 8'h00);
			@(posedge clk);
			src.sources <= i[3] ? 8'hff : 8'h00;
			wr(ADDR_INPUT_CLK, {4'h0, i[3], i[2:0]});
			cyc(4);
			wr(ADDR_STATUS_MASK, 8'h08);
			wr(ADDR_MODE_CTRL, 8'h07);
			cyc(4);
			@(posedge clk);
			// only the selected bit moves, so a wrong pick leaves the flag clear
			src.sources <= src.sources ^ (8'h01 << i[2:0]);
			cyc(6);
			rd(ADDR_STATUS_MASK, 8'h80, {i[2:0] != 3'h7, 7'h0}, "input flag");
			chk("irq raised", {7'h0, i[2:0] != 3'h7}, {7'h0, irq});
			wr(ADDR_STATUS_MASK, 8'h08);
			cyc(2);
			@(negedge clk);
			chk("irq cleared", 8'h00, {7'h0, irq});
		end
		wr(ADDR_MODE_CTRL, 8'h00);
		wr(ADDR_INPUT_CLK, 8'h00);
		src.sources <= 8'h00;
		wr(ADDR_STATUS_MASK, 8'h00);
		wr(ADDR_MODE_CTRL, 8'h07);
		@(posedge clk);
		src.sources <= 8'h01;
		cyc(6);
		rd(ADDR_STATUS_MASK, 8'h80, 8'h80, "unmasked flag");
		chk("irq masked", 8'h00, {7'h0, irq});
		$display("test inputs done");
		// event mode stops on the masked low carry
		for (i = 0; i < 2; i++) begin
			wr(ADDR_MODE_CTRL, 8'h00);
			wr(ADDR_INPUT_CLK, {i[0], 7'h0});
			wr(ADDR_STATUS_MASK, 8'h04);
			wr(ADDR_MODE_CTRL, 8'h01);
			cyc(300);
			rd(ADDR_STATUS_MASK, 8'he0, {2'b01, ~i[0], 5'h0}, "carry flags");
			if (i == 1) rd(ADDR_COUNT_HIGH, 8'hff, 8'h01, "chained high");
			wr(ADDR_MODE_CTRL, 8'h00);
			cyc(2);
			rd(ADDR_COUNT_LOW, 8'hff, 8'h00, "low cleared");
			rd(ADDR_COUNT_HIGH, 8'hff, 8'h00, "high cleared");
		end
		$display("test counters done");
		// pulse width measurement
		@(posedge clk);
		src.sources <= 8'h00;
		wr(ADDR_STATUS_MASK, 8'h01);
		wr(ADDR_MODE_CTRL, 8'h03);
		cyc(4);
		src.sources <= 8'h01;
		cyc(20);
		src.sources <= 8'h00;
		cyc(8);
		rd(ADDR_STATUS_MASK, 8'h10, 8'h10, "done flag");
		chk("done irq", 8'h01, {7'h0, irq});
		// the count equals the 20 cycles the input stayed high
		rd(ADDR_COUNT_LOW, 8'hff, 8'h14, "pulse width");
		wr(ADDR_MODE_CTRL, 8'h00);
		cyc(2);
		rd(ADDR_COUNT_LOW, 8'hff, 8'h00, "width cleared");
		$display("test pulse done");
		// period measurement, rising edges ten cycles apart
		wr(ADDR_STATUS_MASK, 8'h01);
		wr(ADDR_MODE_CTRL, 8'h05);
		cyc(4);
		src.sources <= 8'h01;
		cyc(5);
		src.sources <= 8'h00;
		cyc(5);
		src.sources <= 8'h01;
		cyc(8);
		rd(ADDR_STATUS_MASK, 8'h10, 8'h10, "period flag");
		rd(ADDR_COUNT_LOW, 8'hff, 8'h0a, "period count");
		$display("test period done");
		tally_and_finish;
	end
endmodule

`default_nettype wire

// [sim/tsc_counter_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========
// port checker for the touch sense counter
module tsc_counter_monitor (
	// clock and reset
	input wire logic                    CLK,
	input wire logic                    RST,
	// register port
	input wire tsc_pkg::tsc_bus_type    BUS,
	input wire logic [7:0]              RDATA,
	// sources, controls, interrupt
	input wire tsc_pkg::tsc_src_type    SRC,
	input wire tsc_pkg::tsc_analog_type ANALOG,
	input wire logic                    IRQ
);
	import tsc_pkg::*;

	logic       en_q;
	logic [3:0] mask_q;

	// mirror of enable and masks, taken from the writes themselves
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			en_q <= 1'b0;
			mask_q <= 4'h0;
		end else if (BUS.wr && BUS.addr == ADDR_MODE_CTRL) begin
			en_q <= BUS.wdata[POS_ENABLE];
		end else if (BUS.wr && BUS.addr == ADDR_STATUS_MASK) begin
			mask_q <= BUS.wdata[3:0];
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	// ==========
	// steps of multi-cycle checks
	sequence wr_at(logic [7:0] a);
		BUS.wr && BUS.addr == a;
	endsequence
	// counts are judged only two cycles after disable, clearing may lag one
	sequence count_read_off;
		BUS.rd && (BUS.addr == ADDR_COUNT_LOW || BUS.addr == ADDR_COUNT_HIGH)
			##0 !en_q && !$past(en_q) && !$past(en_q, 2);
	endsequence

	// ==========
	// assertions
	rdata_idle_a: assert property (!$past(BUS.rd) |-> RDATA == 8'h00)
		else $error("read data not zero outside read");
	unmapped_read_a: assert property (BUS.rd && BUS.addr < 8'ha0 |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	count_cleared_a: assert property (count_read_off |=> RDATA == 8'h00)
		else $error("count not zero while disabled");
	shield_write_a: assert property (wr_at(ADDR_SHIELD_REF) |-> ##2
		ANALOG.shield_enable == {$past(BUS.wdata[7], 2), $past(BUS.wdata[3:0], 2)})
		else $error("shield enables differ from write");
	timer_write_a: assert property (wr_at(ADDR_TIMER_VALUE) |-> ##2
		{ANALOG.dual_dac_select, ANALOG.timer_count} == $past(BUS.wdata, 2))
		else $error("timer fields differ from write");
	slew_write_a: assert property (wr_at(ADDR_SLEW_CTRL) |-> ##2
		ANALOG.fast_slew_enable == $past(BUS.wdata[0], 2))
		else $error("fast slew differs from write");
	scale_write_a: assert property (wr_at(ADDR_SWITCH_CTRL) |-> ##2
		ANALOG.current_scale_sel == $past(BUS.wdata[6], 2))
		else $error("scale select differs from write");
	dac_connect_a: assert property (BUS.wr && BUS.addr == ADDR_SWITCH_CTRL
		&& (BUS.wdata[4] || BUS.wdata[2]) |-> ##2 ANALOG.dac_bus_connect)
		else $error("dac not connected");
	// a switch write in the next cycle may turn the pins on again, so that case is left out
	pins_quiet_a: assert property ((wr_at(ADDR_SWITCH_CTRL) ##0 !BUS.wdata[2]
		##1 !(BUS.wr && BUS.addr == ADDR_SWITCH_CTRL)) |-> ##1 !ANALOG.pin_switch [*2])
		else $error("pin switching while disabled");
	irq_masked_a: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0
		&& $past(mask_q, 2) == 4'h0 |-> !IRQ)
		else $error("interrupt with all masks clear");
endmodule

bind tsc_counter tsc_counter_monitor i_tsc_counter_monitor (
	.CLK    (CLK),
	.RST    (RST),
	.BUS    (BUS),
	.RDATA  (RDATA),
	.SRC    (SRC),
	.ANALOG (ANALOG),
	.IRQ    (IRQ)
);

`default_nettype wire
